// >>> hw/scl_loader.sv
// serial-flash configuration reader: straps, command phase, bitstream read
`timescale 1ns/10ps
module scl_loader
  import scl_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = scl_pkg::CFG_HALF_CYCLES
) (
  input  wire logic       mclk,               // system clock, 10 MHz
  input  wire logic       rst,                // internal power-on reset
  input  wire logic       program_n,          // full-chip reset pin
  input  wire logic       init_n,             // configuration hold pin
  input  wire logic       done_in,            // configuration complete pin
  input  wire logic [2:0] boot_mode,          // boot mode straps
  input  wire logic [2:0] variant_select,     // read variant straps
  input  wire logic [7:0] read_opcode_strap,  // opcode straps
  input  wire logic       data_in,            // serial data from flash
  input  wire logic       data_ready,         // receiver takes byte
  output logic            config_clock,       // clock to flash
  output logic            flash_select_n,     // flash select
  output logic            flash_select_n_oe,  // select driven
  output logic            mosi,               // serial data to flash
  output logic            mosi_oe,            // serial out driven
  output logic            chain_out,          // bits forwarded downstream
  output logic [7:0]      data_byte,          // bitstream byte
  output logic            data_valid,         // byte present
  output logic            loading,            // configuration in progress
  output logic            cfg_error           // reserved variant strapped
);
  import scl_pkg::*;

  localparam logic [PHASE_W-1:0] PH_RISE = PHASE_W'(HALF_CYCLES - 1);
  localparam logic [PHASE_W-1:0] PH_FALL = PHASE_W'(2 * HALF_CYCLES - 1);

  // three-stage synchronisers; a change counts when stages two and three agree
  logic [2:0] prog_sync_q, init_sync_q, done_sync_q;
  logic       prog_lvl_q, init_lvl_q, done_lvl_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_sync_q <= 3'h0;
      init_sync_q <= 3'h0;
      done_sync_q <= 3'h0;
      prog_lvl_q  <= 1'b0;
      init_lvl_q  <= 1'b0;
      done_lvl_q  <= 1'b0;
    end else begin
      prog_sync_q <= {prog_sync_q[1:0], program_n};
      init_sync_q <= {init_sync_q[1:0], init_n};
      done_sync_q <= {done_sync_q[1:0], done_in};
      if (prog_sync_q[1] == prog_sync_q[2]) prog_lvl_q <= prog_sync_q[2];
      if (init_sync_q[1] == init_sync_q[2]) init_lvl_q <= init_sync_q[2];
      if (done_sync_q[1] == done_sync_q[2]) done_lvl_q <= done_sync_q[2];
    end
  end

  wire init_new  = (init_sync_q[1] == init_sync_q[2]) ? init_sync_q[2] : init_lvl_q;
  // chip reset also holds the loader: once it lets go with the hold pin high,
  // that counts as a fresh hold-pin rise, so a release of program_n restarts
  wire init_rise = init_new && !armed_q;

  // strap capture on the hold pin's rising edge
  logic [2:0] mode_q;
  logic [2:0] var_q;
  logic [7:0] strap_q;
  logic       armed_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q  <= 3'h0;
      var_q   <= 3'h0;
      strap_q <= 8'h00;
      armed_q <= 1'b0;
    end else if (!prog_lvl_q) begin
      armed_q <= 1'b0;
    end else if (init_rise) begin
      mode_q  <= boot_mode;
      var_q   <= variant_select;
      strap_q <= read_opcode_strap;
      armed_q <= 1'b1;
    end
  end

  function automatic logic [7:0] scl_opcode(input logic [2:0] v, input logic [7:0] s);
    case (v)
      VAR_OP_FF:    scl_opcode = OPC_FF;
      VAR_STRAPPED: scl_opcode = s;
      VAR_OP_52:    scl_opcode = OPC_52;
      VAR_OP_55:    scl_opcode = OPC_55;
      VAR_OP_03:    scl_opcode = OPC_03;
      VAR_OP_E8:    scl_opcode = OPC_E8;
      VAR_OP_0B:    scl_opcode = OPC_0B;
      default:      scl_opcode = OPC_FF;
    endcase
  endfunction : scl_opcode

  wire [7:0] opcode   = scl_opcode(var_q, strap_q);
  wire       fast_op  = (opcode == OPC_0B) || (opcode == OPC_E8);
  wire [5:0] cmd_bits = fast_op ? CMD_BITS_FAST : CMD_BITS;
  wire       is_sfm   = (mode_q == MODE_SERIAL_FLASH);
  wire       start_ok = armed_q && prog_lvl_q && is_sfm;

  scl_state_type      state_q;
  logic [PHASE_W-1:0] ph_q;
  logic               clk_q, sel_q, sel_oe_q, mosi_q, mosi_oe_q, chain_q;
  logic [39:0]        cmd_sh_q;
  logic [5:0]         bit_cnt_q;
  logic [7:0]         rx_sh_q;
  logic [2:0]         rx_cnt_q;
  logic               push_q;
  logic [7:0]         push_byte_q;
  logic               buf_in_ready;

  wire running  = (state_q == SCL_SEND) || (state_q == SCL_READ);
  // the clock halts while the buffer is full so no byte is lost
  wire advance  = running && buf_in_ready && !push_q;
  wire at_rise  = advance && (ph_q == PH_RISE);
  wire at_fall  = advance && (ph_q == PH_FALL);
  wire last_cmd = (bit_cnt_q == cmd_bits - 6'h1);
  wire rx_full  = (rx_cnt_q == 3'h7);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q     <= SCL_WAIT;
      ph_q        <= '0;
      clk_q       <= 1'b0;
      sel_q       <= 1'b1;
      sel_oe_q    <= 1'b0;
      mosi_q      <= 1'b0;
      mosi_oe_q   <= 1'b0;
      chain_q     <= 1'b0;
      cmd_sh_q    <= '0;
      bit_cnt_q   <= 6'h0;
      rx_sh_q     <= 8'h00;
      rx_cnt_q    <= 3'h0;
      push_q      <= 1'b0;
      push_byte_q <= 8'h00;
    end else begin
      push_q <= 1'b0;
      if (advance) begin
        ph_q <= (ph_q == PH_FALL) ? '0 : ph_q + PHASE_W'(1);
      end
      if (at_rise) clk_q <= 1'b1;
      if (at_fall) clk_q <= 1'b0;
      if (!prog_lvl_q && state_q != SCL_WAIT) begin
        state_q   <= SCL_WAIT;
        clk_q     <= 1'b0;
        sel_q     <= 1'b1;
        sel_oe_q  <= 1'b0;
        mosi_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          SCL_WAIT: begin
            if (start_ok && var_q == VAR_RESERVED) begin
              state_q <= SCL_ERROR;
            end else if (start_ok) begin
              state_q   <= SCL_SEND;
              ph_q      <= '0;
              sel_q     <= 1'b0;
              sel_oe_q  <= 1'b1;
              mosi_oe_q <= 1'b1;
              mosi_q    <= opcode[7];
              cmd_sh_q  <= {opcode[6:0], START_ADDR, DUMMY_BYTE, 1'b0};
              bit_cnt_q <= 6'h0;
              rx_cnt_q  <= 3'h0;
            end
          end
          SCL_SEND: begin
            if (at_fall) begin
              mosi_q    <= cmd_sh_q[39];
              cmd_sh_q  <= {cmd_sh_q[38:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 6'h1;
              if (last_cmd) state_q <= SCL_READ;
            end
          end
          SCL_READ: begin
            if (at_rise) begin
              rx_sh_q  <= {rx_sh_q[6:0], data_in};
              chain_q  <= data_in;
              rx_cnt_q <= rx_cnt_q + 3'h1;
              if (rx_full) begin
                push_q      <= 1'b1;
                push_byte_q <= {rx_sh_q[6:0], data_in};
              end
            end
            if (at_fall && done_lvl_q) begin
              state_q   <= SCL_RELEASE;
              clk_q     <= 1'b0;
              sel_q     <= 1'b1;
            end
          end
          SCL_RELEASE: begin
            // pins go to user logic; a pull-up keeps select high
            sel_oe_q  <= 1'b0;
            mosi_oe_q <= 1'b0;
            if (!armed_q) state_q <= SCL_WAIT;
          end
          SCL_ERROR: begin
            if (!armed_q) state_q <= SCL_WAIT;
          end
          default: state_q <= SCL_WAIT;
        endcase
      end
    end
  end

  // an unmapped value keeps loading low and is flagged on cfg_error, registered from the error state
  logic busy_q, err_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      busy_q <= running;
      err_q  <= (state_q == SCL_ERROR);
    end
  end

  logic [7:0] buf_data;
  logic       buf_valid;

  scl_buf2 #(.WIDTH(8)) u_buf (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (push_byte_q),
    .in_valid  (push_q),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (data_ready)
  );

  assign config_clock      = clk_q;
  assign flash_select_n    = sel_q;
  assign flash_select_n_oe = sel_oe_q;
  assign mosi              = mosi_q;
  assign mosi_oe           = mosi_oe_q;
  assign chain_out         = chain_q;
  assign data_byte         = buf_data;
  assign data_valid        = buf_valid;
  assign loading           = busy_q;
  assign cfg_error         = err_q;
endmodule : scl_loader

// >>> hw/scl_pkg.sv
// constants shared by the serial-flash configuration loader
package scl_pkg;
  localparam int unsigned MCLK_PERIOD_NS   = 100;
  localparam int unsigned CFG_CLK_PERIOD_NS = 800;
  localparam int unsigned CFG_HALF_CYCLES  = CFG_CLK_PERIOD_NS / MCLK_PERIOD_NS / 2;
  localparam int unsigned PHASE_W          = 3;

  localparam logic [2:0] MODE_SERIAL_FLASH = 3'h1;

  localparam logic [2:0] VAR_OP_FF     = 3'h0;
  localparam logic [2:0] VAR_STRAPPED  = 3'h1;
  localparam logic [2:0] VAR_OP_52     = 3'h2;
  localparam logic [2:0] VAR_RESERVED  = 3'h3;
  localparam logic [2:0] VAR_OP_55     = 3'h4;
  localparam logic [2:0] VAR_OP_03     = 3'h5;
  localparam logic [2:0] VAR_OP_E8     = 3'h6;
  localparam logic [2:0] VAR_OP_0B     = 3'h7;

  localparam logic [7:0] OPC_FF = 8'hff;
  localparam logic [7:0] OPC_52 = 8'h52;
  localparam logic [7:0] OPC_55 = 8'h55;
  localparam logic [7:0] OPC_03 = 8'h03;
  localparam logic [7:0] OPC_E8 = 8'he8;
  localparam logic [7:0] OPC_0B = 8'h0b;

  localparam logic [23:0] START_ADDR   = 24'h000000;
  localparam logic [7:0]  DUMMY_BYTE   = 8'h00;
  localparam logic [5:0]  CMD_BITS     = 6'h20;
  localparam logic [5:0]  CMD_BITS_FAST = 6'h28;

  typedef enum logic [2:0] {
    SCL_WAIT    = 3'b000,
    SCL_SEND    = 3'b001,
    SCL_READ    = 3'b010,
    SCL_RELEASE = 3'b011,
    SCL_ERROR   = 3'b100
  } scl_state_type;
endpackage : scl_pkg

// >>> hw/scl_buf2.sv
// two-entry buffer with valid/ready on both sides; out_data and out_valid registered, in_ready decoded from the count
`timescale 1ns/10ps
module scl_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             mclk,      // system clock
  input  wire logic             rst,       // async reset, active high
  input  wire logic [WIDTH-1:0] in_data,   // word from loader
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room for a word
  output logic      [WIDTH-1:0] out_data,  // word to receiver
  output logic                  out_valid, // word present
  input  wire logic             out_ready  // receiver takes word
);
  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic [1:0]       cnt_q;
  logic [1:0]       cnt_d;
  logic             valid_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      head_q <= '0;
      tail_q <= '0;
      cnt_q  <= 2'h0;
      valid_q <= 1'b0;
    end else begin
      if (pop) begin
        head_q <= (cnt_q == 2'h2) ? tail_q : in_data;
      end else if (push && cnt_q == 2'h0) begin
        head_q <= in_data;
      end
      if (push && ((cnt_q == 2'h1 && !pop) || cnt_q == 2'h2)) begin
        tail_q <= in_data;
      end
      cnt_q <= cnt_d;
      // valid kept in its own flop so the loader's output comes from a register
      valid_q <= (cnt_d != 2'h0);
    end
  end

  // with a pop and push at count one the new word goes straight to the head
  assign out_data  = head_q;
  assign out_valid = valid_q;
  assign in_ready  = (cnt_q != 2'h2);
endmodule : scl_buf2

// >>> test/scl_flash_model.sv
// serial flash answering any read with a fixed byte pattern
`timescale 1ns/10ps
module scl_flash_model (
  input  wire logic        config_clock,   // clock from loader
  input  wire logic        flash_select_n, // select
  input  wire logic        mosi,           // command bits
  output logic             data_in,        // data to loader
  output logic [31:0]      cmd_q           // opcode and address seen
);
  logic [15:0] nbit_q = 16'h0000;
  logic        out_q = 1'b1;
  wire  [15:0] clen = (cmd_q[31:24] == 8'h0b || cmd_q[31:24] == 8'he8) ? 16'h0028 : 16'h0020;
  wire  [15:0] didx = nbit_q - clen;
  wire  [7:0]  byte_w = didx[10:3] ^ 8'ha5;
  // always awake: takes a command as soon as it is selected
  // deselect restarts the bit count, so every new select starts a fresh command
  always @(posedge config_clock or posedge flash_select_n) begin
    if (flash_select_n) begin
      nbit_q <= 16'h0000;
    end else begin
      if (nbit_q < 16'h0020) cmd_q <= {cmd_q[30:0], mosi};
      nbit_q <= nbit_q + 16'h0001;
    end
  end
  // shift on the fall so the loader finds the bit settled at the rise
  always @(negedge config_clock) out_q <= nbit_q < clen ? 1'b1 : byte_w[~didx[2:0]];
  // pull-up wins whenever the flash is not selected
  assign data_in = flash_select_n ? 1'b1 : out_q;
endmodule : scl_flash_model

// >>> test/scl_loader_checker.sv
// assertions on the configuration loader ports
`timescale 1ns/10ps
module scl_loader_checker
  import scl_pkg::*;
#(
  parameter int HALF_CYCLES = 4
) (
  input wire logic       mclk,              // clock
  input wire logic       rst,               // reset
  input wire logic       program_n,         // chip reset
  input wire logic       init_n,            // hold pin
  input wire logic       done_in,           // complete
  input wire logic [2:0] boot_mode,         // mode strap
  input wire logic [2:0] variant_select,    // variant strap
  input wire logic       data_ready,        // byte taken
  input wire logic       config_clock,      // flash clock
  input wire logic       flash_select_n,    // select
  input wire logic       flash_select_n_oe, // select drive
  input wire logic       mosi,              // data out
  input wire logic       mosi_oe,           // data drive
  input wire logic       data_valid,        // byte present
  input wire logic       loading,           // busy
  input wire logic       cfg_error          // bad variant
);
  logic [15:0] hi_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // a stalled clock may stay high longer, never shorter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) hi_q <= 16'h0000;
    else hi_q <= config_clock ? hi_q + 16'h0001 : 16'h0000;
  end
  property p_start;
    $fell(flash_select_n) |-> flash_select_n_oe && !config_clock ##HALF_CYCLES $rose(config_clock);
  endproperty
  a_start: assert property (p_start) else $error("select fell without clean start");
  property p_mosi_edge;
    $changed(mosi) && mosi_oe && $past(mosi_oe) |-> $fell(config_clock);
  endproperty
  a_mosi_edge: assert property (p_mosi_edge) else $error("data out moved off fall");
  property p_half;
    $fell(config_clock) && program_n |-> hi_q >= HALF_CYCLES;
  endproperty
  a_half: assert property (p_half) else $error("clock high phase too short");
  property p_done;
    done_in [*8] |-> ##[0:16] !flash_select_n_oe && !mosi_oe && !loading;
  endproperty
  a_done: assert property (p_done) else $error("pins not released after done");
  property p_keep_off;
    done_in && !flash_select_n_oe |=> !flash_select_n_oe;
  endproperty
  a_keep_off: assert property (p_keep_off) else $error("select driven after done");
  property p_mode;
    boot_mode != MODE_SERIAL_FLASH |-> !flash_select_n_oe;
  endproperty
  a_mode: assert property (p_mode) else $error("select driven in other mode");
  property p_reserved;
    (variant_select == VAR_RESERVED && boot_mode == MODE_SERIAL_FLASH && init_n && program_n) [*8]
      |-> cfg_error && !flash_select_n_oe;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved variant not refused");
  property p_hold;
    !init_n && !loading |=> !loading;
  endproperty
  a_hold: assert property (p_hold) else $error("started while held");
  property p_prog;
    !program_n [*8] |-> !flash_select_n_oe && !mosi_oe && !loading;
  endproperty
  a_prog: assert property (p_prog) else $error("active during chip reset");
  c_sel: cover property ($fell(flash_select_n));
  c_full: cover property (data_valid && !data_ready);
  c_err: cover property (cfg_error);
endmodule : scl_loader_checker

bind scl_loader scl_loader_checker #(.HALF_CYCLES(HALF_CYCLES)) i_chk (
  .mclk, .rst, .program_n, .init_n, .done_in, .boot_mode, .variant_select, .data_ready,
  .config_clock, .flash_select_n, .flash_select_n_oe, .mosi, .mosi_oe, .data_valid,
  .loading, .cfg_error);

// >>> test/spi_master_config_read_tb.sv
// bench for the serial-flash configuration loader
`timescale 1ns/10ps
module spi_master_config_read_tb;
  import scl_pkg::*;
  logic       mclk, rst, program_n, init_n, done_in, data_ready, stall;
  logic [2:0] boot_mode, variant_select;
  logic [7:0] read_opcode_strap, data_byte;
  logic       data_in, config_clock, flash_select_n, flash_select_n_oe, mosi, mosi_oe;
  logic       chain_out, data_valid, loading, cfg_error;
  logic [31:0] cmd_q;
  logic [7:0] op_tab [8] = '{8'hff, 8'h00, 8'h52, 8'h00, 8'h55, 8'h03, 8'he8, 8'h0b};
  int         seed = 85252;
  int         err_count, total_checks, nbytes, cyc, nrise;
  logic       clk_d;

  scl_loader i_dut (.mclk, .rst, .program_n, .init_n, .done_in, .boot_mode, .variant_select,
    .read_opcode_strap, .data_in, .data_ready, .config_clock, .flash_select_n,
    .flash_select_n_oe, .mosi, .mosi_oe, .chain_out, .data_byte, .data_valid, .loading,
    .cfg_error);
  scl_flash_model i_flash (.config_clock, .flash_select_n, .mosi, .data_in, .cmd_q);

  always #50 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // random back-pressure, plus a long stall when asked; also the hang limit
  always @(posedge mclk) begin
    data_ready <= !stall && ($random(seed) % 2 != 0);
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end

  // every popped byte must continue the flash pattern with nothing lost
  always @(posedge mclk) begin
    if (data_valid && data_ready) begin
      check(data_byte, nbytes[7:0] ^ 8'ha5);
      nbytes++;
    end
  end

  // past any command length the forwarded bit is the one sampled at the last rise
  always @(posedge mclk) begin
    clk_d <= config_clock;
    if (flash_select_n) nrise <= 0;
    else if (config_clock && !clk_d) nrise <= nrise + 1;
    if (config_clock && clk_d && nrise > 40) check(chain_out, data_in);
  end

  task automatic run(input logic [2:0] m, input logic [2:0] v, input logic [7:0] s,
                     input logic ab);
    int i;
    int nb;
    rst <= 1'b1;
    done_in <= 1'b0;
    init_n <= 1'b0;
    program_n <= 1'b1;
    boot_mode <= m;
    variant_select <= v;
    read_opcode_strap <= s;
    repeat (20) @(posedge mclk);
    nbytes = 0;
    rst <= 1'b0;
    repeat (30) @(posedge mclk);
    check(loading, 1'b0);
    init_n <= 1'b1;
    for (i = 0; i < 40 && flash_select_n; i++) @(posedge mclk);
    check(flash_select_n, m != MODE_SERIAL_FLASH || v == VAR_RESERVED);
    check(cfg_error, v == VAR_RESERVED);
    if (flash_select_n) return;
    stall <= (v == VAR_OP_0B);
    repeat (600) @(posedge mclk);
    stall <= 1'b0;
    for (i = 0; i < 2000 && nbytes < 3; i++) @(posedge mclk);
    check(nbytes >= 3, 1'b1);
    check(cmd_q, {(v == VAR_STRAPPED) ? s : op_tab[v], 24'h000000});
    if (ab) begin
      program_n <= 1'b0;
      repeat (12) @(posedge mclk);
      check({flash_select_n_oe, mosi_oe, loading}, 3'h0);
      program_n <= 1'b1;
      for (i = 0; i < 40 && flash_select_n; i++) @(posedge mclk);
      check(flash_select_n, 1'b0);
      nbytes = 0;
      for (i = 0; i < 1000 && nbytes < 1; i++) @(posedge mclk);
      check(nbytes >= 1, 1'b1);
    end else begin
      done_in <= 1'b1;
      repeat (30) @(posedge mclk);
      check({flash_select_n_oe, mosi_oe, loading}, 3'h0);
      nb = nbytes;
      repeat (100) @(posedge mclk);
      check(nbytes, nb);
    end
  endtask : run

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {program_n, init_n, done_in, data_ready, stall} = 5'h10;
    {boot_mode, variant_select, read_opcode_strap} = 14'h0000;
    for (int v = 0; v < 8; v++) run(MODE_SERIAL_FLASH, v[2:0], 8'($random(seed)), 1'b0);
    run(3'h2, VAR_OP_03, 8'h00, 1'b0);
    run(MODE_SERIAL_FLASH, VAR_STRAPPED, 8'h0b, 1'b0);
    run(MODE_SERIAL_FLASH, VAR_OP_03, 8'h00, 1'b1);
    test_done();
  end
endmodule : spi_master_config_read_tb
